// ### hw/fnd_pkg.sv
// Constants shared by the fractional-N divider and reference path
package fnd_pkg;
    // ==========================================
    // Register port
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 32;
    localparam logic [7:0]  OFS_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_PREDIV = 8'h04;
    localparam logic [7:0]  OFS_MULT   = 8'h08;
    localparam logic [7:0]  OFS_POSTDV = 8'h0C;
    localparam logic [7:0]  OFS_NINT   = 8'h10;
    localparam logic [7:0]  OFS_NUM    = 8'h14;
    localparam logic [7:0]  OFS_DEN    = 8'h18;
    localparam logic [7:0]  OFS_STATUS = 8'h1C;
    // ==========================================
    // Control field positions
    localparam int unsigned POS_DBL    = 0;
    localparam int unsigned POS_PRE    = 1;
    localparam int unsigned POS_MULT   = 2;
    localparam int unsigned POS_POST   = 3;
    localparam int unsigned POS_PSC4   = 4;
    localparam int unsigned POS_ORDER  = 5;
    localparam int unsigned POS_LOOP   = 8;
    localparam int unsigned POS_LOWADJ = 10;
    localparam int unsigned POS_HIADJ  = 12;
    localparam int unsigned POS_DLY    = 16;
    // ==========================================
    // Status field positions
    localparam int unsigned POS_ST_UP   = 16;
    localparam int unsigned POS_ST_DN   = 17;
    localparam int unsigned POS_ST_PSC4 = 18;
    localparam int unsigned POS_ST_SGL  = 19;
    // ==========================================
    // Field widths and encodings
    localparam int unsigned N_W       = 12;
    localparam int unsigned DIV_W     = 8;
    localparam int unsigned MULT_W    = 5;
    localparam int unsigned PER_W     = 16;
    localparam int unsigned OFS_W     = 5;
    localparam int unsigned STAGES    = 4;
    localparam logic [1:0]  ADJ_EXT   = 2'h3;
    localparam logic [1:0]  LOOP_SGL  = 2'h3;
    // ==========================================
    // Reset values
    localparam logic [31:0] CTRL_RST  = 32'h0001_0000;
    localparam logic [7:0]  DIV_RST   = 8'h01;
    localparam logic [4:0]  MULT_RST  = 5'h01;
    localparam logic [11:0] NINT_RST  = 12'h010;
    localparam logic [31:0] NUM_RST   = 32'h0000_0000;
    localparam logic [31:0] DEN_RST   = 32'h0000_0001;
    // ==========================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 5;
endpackage

// ### hw/fnd_sdm_if.sv
// Link between divider control and the noise-shaping modulator
interface fnd_sdm_if;
    logic                    step;
    logic [2:0]              order;
    logic [31:0]             num;
    logic [31:0]             den;
    logic signed [4:0]       offset;
    modport ctl (output step, order, num, den, input offset);
    modport sdm (input step, order, num, den, output offset);
endinterface

// ### hw/fnd_sdm.sv
// Multi-stage noise-shaping modulator, one to four cascaded stages
module fnd_sdm (
    input  wire logic clock,
    input  wire logic reset,
    fnd_sdm_if.sdm    bus
);
    typedef struct packed {
        logic [3:0][31:0]        acc;
        logic [3:0][5:0]         dprev;
        logic signed [4:0]       offset;
    } fnd_sdm_st_t;

    fnd_sdm_st_t q;
    fnd_sdm_st_t n;
    logic [31:0] den_eff;
    logic [31:0] num_eff;
    logic [3:0][31:0] stg_in;
    logic [3:0][31:0] acc_new;
    logic [3:0]       carry;

    // ==========================================
    // Operand guarding
    assign den_eff = (bus.den == 32'h0) ? 32'h1 : bus.den;
    assign num_eff = (bus.num >= den_eff) ? den_eff - 32'h1 : bus.num;

    // ==========================================
    // Cascaded accumulators; stages beyond the order stay at zero
    for (genvar i = 0; i < 4; i++) begin : g_stage
        logic [32:0] sum;
        logic        act;
        if (i == 0) begin : g_first
            assign stg_in[i] = num_eff;
        end else begin : g_next
            assign stg_in[i] = acc_new[i-1];
        end
        assign act = (3'(i) < bus.order);
        assign sum = {1'b0, q.acc[i]} + {1'b0, stg_in[i]};
        assign carry[i] = act && (sum >= {1'b0, den_eff});
        assign acc_new[i] = !act ? 32'h0 :
                            carry[i] ? 32'(sum - {1'b0, den_eff}) :
                            sum[31:0];
    end

    // ==========================================
    // Error cancellation network, last stage first
    always_comb begin
        logic signed [5:0] d;
        d = 6'sh00;
        n = q;
        if (bus.step) begin
            for (int k = 3; k >= 0; k--) begin
                // Skip the history of idle stages so a lower order starts clean
                d = $signed({5'h00, carry[k]}) + d
                    - ((k < 3 && 3'(k + 1) < bus.order) ?
                       $signed(q.dprev[k+1]) : 6'sh00);
                n.dprev[k] = d;
                n.acc[k] = acc_new[k];
            end
            n.offset = (bus.order == 3'h0) ? 5'sh00 : 5'(d);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign bus.offset = q.offset;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    AST_SDM_ACC_LT_DEN: assert property (
        bus.step |=> q.acc[0] < den_eff)
        else $error("first accumulator not below denominator");
    AST_SDM_INT_BYPASS: assert property (
        (bus.step && bus.order == 3'h0) |=> q.offset == 5'sh00)
        else $error("integer mode produced an offset");
    AST_SDM_FIRST_RANGE: assert property (
        (bus.step && bus.order == 3'h1) |=>
            (q.offset == 5'sh00 || q.offset == 5'sh01))
        else $error("first order offset out of range");
    COV_SDM_FOURTH: cover property (bus.step && bus.order == 3'h4);
endmodule

// ### hw/fnd_divider.sv
// Reference path, phase detector and fractional feedback divider
// Notes on behaviour
// - Integer divide setting is twelve bits wide.
// - Modulator order selectable one through four.
// - Denominator any value from one upward.
// - Average division is integer plus fraction.
// - Prescaler divides feedback input by two or four.
// - Detector pulses until both edges align.
// - Dual-loop detector is the reset default.
// - Every reference stage can be bypassed.
// - Doubler uses both input edges.
// - Pre-divider divides before multiplier stage.
// - Post-divider reaches low comparison rates.
//
// Our own choices: the placing of the registers and the strobed register port.
module fnd_divider (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rdata,
    input  wire logic        reference_input,
    input  wire logic        vco_feedback,
    output logic             ref_cmp_pulse,
    output logic             fb_cmp_pulse,
    output logic             pump_up,
    output logic             pump_down
);
    typedef struct packed {
        logic [31:0]                  ctrl;
        logic [fnd_pkg::DIV_W-1:0]    prediv;
        logic [fnd_pkg::MULT_W-1:0]   mult;
        logic [fnd_pkg::DIV_W-1:0]    postdv;
        logic [fnd_pkg::N_W-1:0]      nint;
        logic [31:0]                  num;
        logic [31:0]                  den;
        logic [31:0]                  rdata;
        logic [2:0]                   ref_s;
        logic                         ref_lvl;
        logic [2:0]                   vco_s;
        logic                         vco_lvl;
        logic                         dbl_p;
        logic [fnd_pkg::DIV_W-1:0]    pre_cnt;
        logic                         pre_p;
        logic [fnd_pkg::PER_W-1:0]    per_cnt;
        logic [fnd_pkg::PER_W-1:0]    per_last;
        logic [fnd_pkg::PER_W:0]      mph;
        logic                         mult_p;
        logic [fnd_pkg::DIV_W-1:0]    post_cnt;
        logic                         ref_cmp;
        logic [1:0]                   psc_cnt;
        logic                         psc_p;
        logic [12:0]                  n_cnt;
        logic [12:0]                  n_mod;
        logic                         fb_cmp;
        logic                         up;
        logic                         dn;
        logic [3:0]                   rst_cnt;
    } fnd_div_st_t;

    fnd_div_st_t q;
    fnd_div_st_t n;

    logic        dbl_en;
    logic        pre_en;
    logic        mult_en;
    logic        post_en;
    logic        psc4;
    logic        single_loop;
    logic [2:0]  order;
    logic [3:0]  dly;
    logic        ref_rise;
    logic        ref_fall;
    logic        vco_rise;
    logic [31:0] status;

    fnd_sdm_if sdm_bus ();

    // ==========================================
    // Decoded control fields
    assign dbl_en  = q.ctrl[fnd_pkg::POS_DBL];
    assign pre_en  = q.ctrl[fnd_pkg::POS_PRE];
    assign mult_en = q.ctrl[fnd_pkg::POS_MULT];
    assign post_en = q.ctrl[fnd_pkg::POS_POST];
    assign order   = q.ctrl[fnd_pkg::POS_ORDER +: 3];
    assign dly     = q.ctrl[fnd_pkg::POS_DLY +: 4];
    // Low comparison rates need the wider prescaler, so force it here
    assign psc4    = q.ctrl[fnd_pkg::POS_PSC4] ||
                     (q.ctrl[fnd_pkg::POS_LOWADJ +: 2] == fnd_pkg::ADJ_EXT);
    assign single_loop =
        (q.ctrl[fnd_pkg::POS_LOOP +: 2] == fnd_pkg::LOOP_SGL);

    // ==========================================
    // Filtered edges: a change counts once stages two and three agree
    assign ref_rise = (q.ref_s[1] == q.ref_s[2]) && q.ref_s[2] && !q.ref_lvl;
    assign ref_fall = (q.ref_s[1] == q.ref_s[2]) && !q.ref_s[2] && q.ref_lvl;
    assign vco_rise = (q.vco_s[1] == q.vco_s[2]) && q.vco_s[2] && !q.vco_lvl;

    assign status = {12'h000, single_loop, psc4, q.dn, q.up, 3'h0, q.n_mod};

    // ==========================================
    // Modulator hookup
    assign sdm_bus.step  = q.fb_cmp;
    assign sdm_bus.order = order;
    assign sdm_bus.num   = q.num;
    assign sdm_bus.den   = q.den;

    fnd_sdm u_sdm (
        .clock (clock),
        .reset (reset),
        .bus   (sdm_bus)
    );

    always_comb begin
        logic signed [13:0] nsum;
        logic [fnd_pkg::PER_W:0] mph_sum;
        nsum    = 14'sh0000;
        mph_sum = '0;
        n = q;
        // ==========================================
        // Register port
        n.rdata = 32'h0000_0000;
        if (wr_en) begin
            case (addr)
                fnd_pkg::OFS_CTRL:   n.ctrl = wdata;
                fnd_pkg::OFS_PREDIV: n.prediv = wdata[fnd_pkg::DIV_W-1:0];
                fnd_pkg::OFS_MULT:   n.mult = wdata[fnd_pkg::MULT_W-1:0];
                fnd_pkg::OFS_POSTDV: n.postdv = wdata[fnd_pkg::DIV_W-1:0];
                fnd_pkg::OFS_NINT:   n.nint = wdata[fnd_pkg::N_W-1:0];
                fnd_pkg::OFS_NUM:    n.num = wdata;
                fnd_pkg::OFS_DEN: begin
                    n.den = (wdata == 32'h0) ? 32'h1 : wdata;
                end
                default: ;
            endcase
        end
        if (rd_en) begin
            case (addr)
                fnd_pkg::OFS_CTRL:   n.rdata = q.ctrl;
                fnd_pkg::OFS_PREDIV: n.rdata = 32'(q.prediv);
                fnd_pkg::OFS_MULT:   n.rdata = 32'(q.mult);
                fnd_pkg::OFS_POSTDV: n.rdata = 32'(q.postdv);
                fnd_pkg::OFS_NINT:   n.rdata = 32'(q.nint);
                fnd_pkg::OFS_NUM:    n.rdata = q.num;
                fnd_pkg::OFS_DEN:    n.rdata = q.den;
                fnd_pkg::OFS_STATUS: n.rdata = status;
                default:             n.rdata = 32'h0000_0000;
            endcase
        end
        // ==========================================
        // Pin synchronisers
        n.ref_s = {q.ref_s[1], q.ref_s[0], reference_input};
        n.vco_s = {q.vco_s[1], q.vco_s[0], vco_feedback};
        if (q.ref_s[1] == q.ref_s[2]) begin
            n.ref_lvl = q.ref_s[2];
        end
        if (q.vco_s[1] == q.vco_s[2]) begin
            n.vco_lvl = q.vco_s[2];
        end
        // ==========================================
        // Doubler: duty cycle away from half skews the doubled edges
        n.dbl_p = ref_rise || (dbl_en && ref_fall);
        // ==========================================
        // Pre-divider
        n.pre_p = 1'b0;
        if (!pre_en) begin
            n.pre_p = q.dbl_p;
        end else if (q.dbl_p) begin
            if (q.pre_cnt + 8'h01 >= q.prediv) begin
                n.pre_cnt = 8'h00;
                n.pre_p   = 1'b1;
            end else begin
                n.pre_cnt = q.pre_cnt + 8'h01;
            end
        end
        // ==========================================
        // Multiplier: period measure plus phase accumulator, no divider
        n.mult_p = 1'b0;
        if (q.pre_p) begin
            n.per_last = q.per_cnt + 16'h0001;
            n.per_cnt  = 16'h0000;
        end else if (q.per_cnt != 16'hFFFF) begin
            n.per_cnt = q.per_cnt + 16'h0001;
        end
        if (!mult_en) begin
            n.mult_p = q.pre_p;
            n.mph    = '0;
        end else if (q.per_last != 16'h0000) begin
            mph_sum = q.mph + 17'(q.mult);
            if (mph_sum >= {1'b0, q.per_last}) begin
                n.mph    = mph_sum - {1'b0, q.per_last};
                n.mult_p = 1'b1;
            end else begin
                n.mph = mph_sum;
            end
        end
        // ==========================================
        // Post-divider feeding the comparison input
        n.ref_cmp = 1'b0;
        if (!post_en) begin
            n.ref_cmp = q.mult_p;
        end else if (q.mult_p) begin
            if (q.post_cnt + 8'h01 >= q.postdv) begin
                n.post_cnt = 8'h00;
                n.ref_cmp  = 1'b1;
            end else begin
                n.post_cnt = q.post_cnt + 8'h01;
            end
        end
        // ==========================================
        // Prescaler
        n.psc_p = 1'b0;
        if (vco_rise) begin
            if (q.psc_cnt == (psc4 ? 2'h3 : 2'h1)) begin
                n.psc_cnt = 2'h0;
                n.psc_p   = 1'b1;
            end else begin
                n.psc_cnt = q.psc_cnt + 2'h1;
            end
        end
        // ==========================================
        // Feedback divider; modulus reloads from the latest offset
        n.fb_cmp = 1'b0;
        if (q.psc_p) begin
            if (q.n_cnt + 13'h0001 >= q.n_mod) begin
                n.n_cnt  = 13'h0000;
                n.fb_cmp = 1'b1;
                nsum = $signed({2'b00, q.nint}) + 14'(sdm_bus.offset);
                n.n_mod = (nsum < 14'sh0001) ? 13'h0001 : nsum[12:0];
            end else begin
                n.n_cnt = q.n_cnt + 13'h0001;
            end
        end
        // ==========================================
        // Phase detector; single loop resets without the delay
        if (q.up && q.dn) begin
            if (single_loop || q.rst_cnt + 4'h1 >= dly) begin
                n.up      = 1'b0;
                n.dn      = 1'b0;
                n.rst_cnt = 4'h0;
            end else begin
                n.rst_cnt = q.rst_cnt + 4'h1;
            end
        end
        if (q.ref_cmp) begin
            n.up = 1'b1;
        end
        if (q.fb_cmp) begin
            n.dn = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            q          <= '0;
            q.ctrl     <= fnd_pkg::CTRL_RST;
            q.prediv   <= fnd_pkg::DIV_RST;
            q.mult     <= fnd_pkg::MULT_RST;
            q.postdv   <= fnd_pkg::DIV_RST;
            q.nint     <= fnd_pkg::NINT_RST;
            q.num      <= fnd_pkg::NUM_RST;
            q.den      <= fnd_pkg::DEN_RST;
            q.n_mod    <= {1'b0, fnd_pkg::NINT_RST};
        end else begin
            q <= n;
        end
    end

    assign rdata         = q.rdata;
    assign ref_cmp_pulse = q.ref_cmp;
    assign fb_cmp_pulse  = q.fb_cmp;
    assign pump_up       = q.up;
    assign pump_down     = q.dn;

    // ==========================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    AST_DBL_FALL_EDGE: assert property (
        (dbl_en && ref_fall) |=> q.dbl_p)
        else $error("doubler missed a falling edge");
    AST_PRE_BYPASS: assert property (
        (!pre_en && q.dbl_p) |=> q.pre_p)
        else $error("pre-divider bypass lost a pulse");
    AST_MULT_BYPASS: assert property (
        (!mult_en && q.pre_p) |=> q.mult_p)
        else $error("multiplier bypass lost a pulse");
    AST_POST_BYPASS: assert property (
        (!post_en && q.mult_p) |=> q.ref_cmp)
        else $error("post-divider bypass lost a pulse");
    AST_DBL_OFF: assert property (
        (!dbl_en && !ref_rise) |=> !q.dbl_p)
        else $error("doubler pulsed while disabled");
    AST_PUMP_SET: assert property (
        q.ref_cmp |=> q.up)
        else $error("reference pulse did not raise pump up");
    AST_PSC_RATIO: assert property (
        (q.psc_p && !psc4 && !$past(psc4)) |->
            q.psc_cnt == 2'h0 && $past(q.psc_cnt) == 2'h1)
        else $error("prescaler by two wrapped wrongly");
    AST_N_BOUND: assert property (
        q.fb_cmp |-> q.n_cnt == 13'h0000 && $past(q.n_cnt) + 13'h0001 >=
                     $past(q.n_mod))
        else $error("feedback pulse before the modulus");
    AST_DET_CLEAR: assert property (
        (q.up && q.dn && !q.ref_cmp && !q.fb_cmp && !single_loop &&
         dly == 4'h1) |=> !q.up && !q.dn)
        else $error("detector did not clear after alignment");
    AST_DEFAULT_DUAL: assert property (
        $fell(reset) |-> !single_loop)
        else $error("detector not dual loop after reset");
    AST_DEN_NONZERO: assert property (
        q.den != 32'h0)
        else $error("denominator held at zero");
    AST_LOW_FORCE_PSC: assert property (
        (q.psc_p && $past(q.ctrl[fnd_pkg::POS_LOWADJ +: 2]) ==
         fnd_pkg::ADJ_EXT) |-> $past(q.psc_cnt) == 2'h3)
        else $error("low mode did not force prescaler four");
    AST_READ_ONE_CYCLE: assert property (
        !$past(rd_en) |-> rdata == 32'h0000_0000)
        else $error("read data outside its cycle");

    COV_FB_PULSE: cover property (q.fb_cmp && order != 3'h0);
    COV_DET_BOTH: cover property (q.up && q.dn);
    COV_MULT_ON:  cover property (mult_en && q.mult_p);
endmodule

// ### testbench/fnd_osc_model.sv
// Free-running reference and VCO feedback sources
module fnd_osc_model #(
    parameter int REF_HALF = 4,
    parameter int VCO_HALF = 2
) (
    input  wire logic clock,
    output logic      reference_input = 1'b0,
    output logic      vco_feedback = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Square waves, equal halves, running from time zero
    int ref_cnt = 0;
    int vco_cnt = 0;
    always @(posedge clock) begin
        ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
        vco_cnt <= (vco_cnt == VCO_HALF - 1) ? 0 : vco_cnt + 1;
        if (ref_cnt == REF_HALF - 1) reference_input <= ~reference_input;
        if (vco_cnt == VCO_HALF - 1) vco_feedback <= ~vco_feedback;
    end
endmodule

// ### testbench/fractional_n_divider_ref_path_tb.sv
// Self-checking bench for the divider and reference path
module fractional_n_divider_ref_path_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Signals
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [31:0] rdata;
    logic        reference_input;
    logic        vco_feedback;
    logic        ref_cmp_pulse;
    logic        fb_cmp_pulse;
    logic        pump_up;
    logic        pump_down;
    logic [31:0] seed = 32'h81CDD427;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          vco_rises = 0;
    int          ref_rises = 0;
    logic        vco_prev = 1'b0;
    logic        ref_prev = 1'b0;
    logic        ref_hit = 1'b0;
    logic        fb_hit = 1'b0;
    // ==========================================
    // Instances
    fnd_divider uut (.clock(clock), .reset(reset), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .reference_input(reference_input), .vco_feedback(vco_feedback),
        .ref_cmp_pulse(ref_cmp_pulse), .fb_cmp_pulse(fb_cmp_pulse),
        .pump_up(pump_up), .pump_down(pump_down));
    fnd_osc_model osc (.clock(clock), .reference_input(reference_input),
        .vco_feedback(vco_feedback));
    initial begin
        forever #(fnd_pkg::CLK_PERIOD_NS / 2.0) clock = ~clock;
    end
    // ==========================================
    // Helpers
    task automatic complete_run();
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    // Delay per order follows the recommended table
    function automatic logic [31:0] ctrl_word(input int ord, input int p4,
                                              input int low, input int lp);
        logic [31:0] dly;
        dly = (ord >= 4) ? 32'h8 : (ord >= 2) ? 32'h2 : 32'h1;
        return (dly << fnd_pkg::POS_DLY) | (32'(ord) << fnd_pkg::POS_ORDER)
             | (32'(p4) << fnd_pkg::POS_PSC4)
             | (32'(low) << fnd_pkg::POS_LOWADJ)
             | (32'(lp) << fnd_pkg::POS_LOOP);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        check(v, exp);
    endtask
    task automatic wait_pulse(input bit sel_ref, input int n);
        repeat (n) begin
            @(negedge clock);
            while ((sel_ref ? ref_cmp_pulse : fb_cmp_pulse) !== 1'b1)
                @(negedge clock);
        end
    endtask
    // Sixteen feedback periods against VCO edges; tolerance covers dither
    task automatic fb_case(input logic [31:0] ctrl, input int n,
                           input int num, input int psc, input int ord,
                           input int tol);
        int start;
        int diff;
        wr(fnd_pkg::OFS_NINT, 32'(n));
        wr(fnd_pkg::OFS_DEN, 32'h4);
        wr(fnd_pkg::OFS_NUM, 32'(num));
        wr(fnd_pkg::OFS_CTRL, ctrl);
        wait_pulse(1'b0, 6);
        start = vco_rises;
        wait_pulse(1'b0, 16);
        diff = vco_rises - start
             - psc * (16 * n + ((ord == 0) ? 0 : 4 * num));
        check(diff <= tol && diff >= -tol, 1'b1);
    endtask
    // ==========================================
    // Edge counters, timeout and detector monitor
    always @(posedge clock) begin
        vco_prev <= vco_feedback;
        ref_prev <= reference_input;
        if (vco_feedback && !vco_prev) vco_rises <= vco_rises + 1;
        if (reference_input && !ref_prev) ref_rises <= ref_rises + 1;
        cycles <= cycles + 1;
        if (cycles == 100000) begin
            bad_count++;
            complete_run();
        end
    end
    always @(negedge clock) begin
        if (ref_hit) check(pump_up, 1'b1);
        if (fb_hit) check(pump_down, 1'b1);
        ref_hit = ref_cmp_pulse === 1'b1 && !reset;
        fb_hit = fb_cmp_pulse === 1'b1 && !reset;
    end
    // ==========================================
    // Main sequence
    logic [7:0]  ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    logic [31:0] rst [7] = '{fnd_pkg::CTRL_RST, 32'h1, 32'h1, 32'h1,
                             32'h10, 32'h0, 32'h1};
    logic [3:0]  stg [8] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'hA, 4'h2, 4'h0,
                             4'h4};
    logic [7:0]  pre [8] = '{8'h3, 8'h1, 8'h3, 8'h1, 8'h2, 8'h0, 8'h3,
                             8'h1};
    logic [7:0]  pst [8] = '{8'h2, 8'h1, 8'h1, 8'h2, 8'h3, 8'h1, 8'h2,
                             8'h1};
    int          twice [8] = '{2, 1, 6, 4, 12, 2, 2, 1};
    initial begin
        logic [31:0] v;
        int          i;
        int          start;
        int          n;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        #1 check({ref_cmp_pulse, fb_cmp_pulse, pump_up, pump_down}, 4'h0);
        for (i = 0; i < 7; i++) rd_check(ofs[i], rst[i]);
        rd(fnd_pkg::OFS_STATUS, v);
        check(v[fnd_pkg::POS_ST_SGL], 1'b0);
        seed = lfsr(seed);
        wr(fnd_pkg::OFS_NUM, seed);
        rd_check(fnd_pkg::OFS_NUM, seed);
        wr(fnd_pkg::OFS_DEN, 32'h0);
        rd_check(fnd_pkg::OFS_DEN, 32'h1);
        wr(fnd_pkg::OFS_DEN, 32'hFFFFFFFF);
        rd_check(fnd_pkg::OFS_DEN, 32'hFFFFFFFF);
        seed = lfsr(seed);
        wr(fnd_pkg::OFS_NINT, seed);
        rd_check(fnd_pkg::OFS_NINT, {20'h0, seed[11:0]});
        wr(8'h20, seed);
        rd_check(8'h20, 32'h0);
        rd_check(fnd_pkg::OFS_CTRL, fnd_pkg::CTRL_RST);
        // Doubler and multiplier are never enabled together
        wr(fnd_pkg::OFS_MULT, 32'h2);
        for (i = 0; i < 8; i++) begin
            wr(fnd_pkg::OFS_PREDIV, 32'(pre[i]));
            wr(fnd_pkg::OFS_POSTDV, 32'(pst[i]));
            wr(fnd_pkg::OFS_CTRL, fnd_pkg::CTRL_RST | 32'(stg[i]));
            wait_pulse(1'b1, 3);
            start = ref_rises;
            wait_pulse(1'b1, 4);
            check(ref_rises - start, 2 * twice[i]);
        end
        // Integer N kept at 30 or more so every order is legal
        for (i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            n = 30 + seed[3:0];
            fb_case(ctrl_word(0, i, 0, 0), n, seed[5:4], 2 + 2 * i, 0, 0);
            rd(fnd_pkg::OFS_STATUS, v);
            check(v[12:0], 13'(n));
        end
        fb_case(ctrl_word(0, 0, 3, 0), 30, 0, 4, 0, 0);
        rd(fnd_pkg::OFS_STATUS, v);
        check(v[fnd_pkg::POS_ST_PSC4], 1'b1);
        // Single loop only while dividing by an integer
        wr(fnd_pkg::OFS_CTRL, ctrl_word(0, 0, 0, 3));
        rd(fnd_pkg::OFS_STATUS, v);
        check(v[fnd_pkg::POS_ST_SGL], 1'b1);
        for (i = 1; i <= 4; i++) begin
            seed = lfsr(seed);
            fb_case(ctrl_word(i, 0, 0, 0), 30, 1 + seed[0], 2, i,
                    (i == 1) ? 0 : 16);
        end
        complete_run();
    end
endmodule
